// *** design/lib_bridge.v ***
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "lib_consts.vh"
module lib_bridge #(
  parameter CMD_NS = `LIB_CMD_NS,
  parameter REC_NS = `LIB_REC_NS
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire [4:0]  av_address,
  input  wire        av_read,
  input  wire        av_write,
  input  wire [31:0] av_writedata,
  output reg  [31:0] av_readdata,
  output wire        av_waitrequest,
  input  wire        up_req,
  input  wire        up_mem,
  input  wire        up_wr,
  input  wire        up_word,
  input  wire        up_claimed,
  input  wire [19:0] up_addr,
  input  wire [15:0] up_wdata,
  output reg         up_ack,
  output reg         up_fwd,
  output reg  [15:0] up_rdata,
  output reg  [19:0] isa_sa,
  output reg         isa_sbhe_n,
  output wire        isa_bale,
  output wire        isa_ior_n,
  output wire        isa_iow_n,
  output wire        isa_memr_n,
  output wire        isa_memw_n,
  output reg  [15:0] isa_d_out,
  output reg         isa_d_oe,
  input  wire [15:0] isa_d_in,
  input  wire        isa_iocs16_n,
  input  wire        isa_iochrdy,
  input  wire [15:0] isa_irq_in,
  output wire        isa_refresh_n,
  output wire [6:0]  isa_dack_n,
  output wire        isa_tc,
  output reg  [15:0] host_irq,
  output wire        irq
);

  localparam CMD_CYC = (CMD_NS + `LIB_CLK_NS - 1) / `LIB_CLK_NS;
  localparam REC_CYC = (REC_NS + `LIB_CLK_NS - 1) / `LIB_CLK_NS;
  localparam integer CMD_M1 = CMD_CYC - 1;
  localparam integer REC_M1 = REC_CYC - 1;
  localparam [7:0] CMD_LD = CMD_M1[7:0];
  localparam [7:0] REC_LD = REC_M1[7:0];
  localparam SW = 34;

  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_CMD  = 3'd2;
  localparam S_RDY  = 3'd3;
  localparam S_REC  = 3'd4;
  localparam S_SET  = 3'd5;

  //////////////////////////////////////////////////////////////////////////
  // fixed ISA outputs: no refresh, no dma, single master
  assign isa_refresh_n = 1'b1;
  assign isa_dack_n    = 7'h7f;
  assign isa_tc        = 1'b0;
  // no master or dma request inputs exist, so no arbitration can happen

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change taken when stages two and three agree
  wire [SW-1:0] pin_raw = {isa_irq_in, isa_d_in, isa_iocs16_n, isa_iochrdy};
  reg  [SW-1:0] s1_reg;
  reg  [SW-1:0] s2_reg;
  reg  [SW-1:0] s3_reg;
  reg  [SW-1:0] pin_reg;
  wire [SW-1:0] pin_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & pin_reg);

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      s1_reg  <= {SW{1'b0}};
      s2_reg  <= {SW{1'b0}};
      s3_reg  <= {SW{1'b0}};
      pin_reg <= {SW{1'b0}};
    end else if (ce) begin
      s1_reg  <= pin_raw;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      pin_reg <= pin_next;
    end
  end

  wire [15:0] irq_pin  = pin_reg[33:18];
  wire [15:0] d_pin    = pin_reg[17:2];
  wire        cs16_n   = pin_reg[1];
  wire        rdy_pin  = pin_reg[0];

  //////////////////////////////////////////////////////////////////////////
  // registers
  reg [`LIB_CTRL_W-1:0] ctrl_reg;
  reg [15:0]            irqen_reg;
  reg [`LIB_EV_W-1:0]   stat_reg;
  reg [`LIB_EV_W-1:0]   mask_reg;
  reg                   av_ack_reg;
  reg [`LIB_EV_W-1:0]   ev;

  wire av_req = av_read | av_write;
  wire av_wr  = av_ack_reg & av_write;
  wire [2:0] av_idx = av_address[4:2];

  assign av_waitrequest = av_req & ~av_ack_reg;
  assign irq = |(stat_reg & mask_reg);

  // serial port base lookup
  function [11:0] com_base;
    input [3:0] sel;
    begin
      case (sel)
        4'h0:    com_base = `LIB_COM_B0;
        4'h1:    com_base = `LIB_COM_B1;
        4'h2:    com_base = `LIB_COM_B2;
        4'h3:    com_base = `LIB_COM_B3;
        4'h4:    com_base = `LIB_COM_B4;
        4'h5:    com_base = `LIB_COM_B5;
        4'h6:    com_base = `LIB_COM_B6;
        4'h7:    com_base = `LIB_COM_B7;
        4'h8:    com_base = `LIB_COM_B8;
        default: com_base = `LIB_COM_B9;
      endcase
    end
  endfunction

  // is this I/O address in one of the free ranges
  function io_free;
    input [11:0] a;
    reg [24*`LIB_IO_NRANGE-1:0] tbl;
    integer i;
    begin
      tbl = `LIB_IO_TABLE;
      io_free = 1'b0;
      for (i = 0; i < `LIB_IO_NRANGE; i = i + 1) begin
        if (a >= tbl[i*24+23 -: 12] && a <= tbl[i*24+11 -: 12]) begin
          io_free = 1'b1;
        end
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // forwarding decision
  wire [11:0] com1_b = com_base(ctrl_reg[`LIB_C_COM1_SEL]);
  wire [11:0] com2_b = com_base(ctrl_reg[`LIB_C_COM2_SEL]);
  wire        io_low = (up_addr[19:12] == 8'h00);
  wire        com1_hit = ctrl_reg[`LIB_C_COM1_EN] & io_low & (up_addr[11:3] == com1_b[11:3]);
  wire        com2_hit = ctrl_reg[`LIB_C_COM2_EN] & io_low & (up_addr[11:3] == com2_b[11:3]);
  wire        own_hit = io_low & (up_addr[11:0] >= `LIB_OWN_LO) & (up_addr[11:0] <= `LIB_OWN_HI);
  // a word access must fit whole: its high byte address is checked as well
  wire [19:0] up_last = up_addr + {19'h00000, up_word};
  wire        last_low = (up_last[19:12] == 8'h00);
  wire        com1_last = ctrl_reg[`LIB_C_COM1_EN] & (up_last[11:3] == com1_b[11:3]);
  wire        com2_last = ctrl_reg[`LIB_C_COM2_EN] & (up_last[11:3] == com2_b[11:3]);
  wire        own_last = (up_last[11:0] >= `LIB_OWN_LO) & (up_last[11:0] <= `LIB_OWN_HI);
  wire        last_ok = last_low & io_free(up_last[11:0]) & ~own_last & ~com1_last & ~com2_last;
  wire        mem_ok = (up_addr >= `LIB_MEM_LO) & (up_addr <= `LIB_MEM_HI) & (up_last <= `LIB_MEM_HI);
  wire        io_ok = io_low & io_free(up_addr[11:0]) & ~own_hit & ~com1_hit & ~com2_hit & last_ok;
  wire        fwd_ok = up_mem ? mem_ok : (io_ok & ~up_claimed);

  //////////////////////////////////////////////////////////////////////////
  // ISA cycle engine
  reg [2:0]  st_reg;
  reg [7:0]  cnt_reg;
  reg        wide_reg;
  reg        split_reg;
  reg        phase_reg;
  reg        wr_reg;
  reg        mem_reg;
  reg [15:0] wdat_reg;

  wire strobe = (st_reg == S_CMD) | (st_reg == S_RDY);
  assign isa_bale   = (st_reg == S_ADDR);
  assign isa_ior_n  = ~(strobe & ~mem_reg & ~wr_reg);
  assign isa_iow_n  = ~(strobe & ~mem_reg & wr_reg);
  assign isa_memr_n = ~(strobe & mem_reg & ~wr_reg);
  assign isa_memw_n = ~(strobe & mem_reg & wr_reg);

  wire done_cmd = ((st_reg == S_CMD) && (cnt_reg == 8'h00) && rdy_pin) ||
                  ((st_reg == S_RDY) && rdy_pin);

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg     <= S_IDLE;
      cnt_reg    <= 8'h00;
      wide_reg   <= 1'b0;
      split_reg  <= 1'b0;
      phase_reg  <= 1'b0;
      wr_reg     <= 1'b0;
      mem_reg    <= 1'b0;
      wdat_reg   <= 16'h0000;
      isa_sa     <= 20'h00000;
      isa_sbhe_n <= 1'b1;
      isa_d_out  <= 16'h0000;
      isa_d_oe   <= 1'b0;
      up_ack     <= 1'b0;
      up_fwd     <= 1'b0;
      up_rdata   <= 16'h0000;
      ev         <= {`LIB_EV_W{1'b0}};
    end else if (ce) begin
      up_ack <= 1'b0;
      ev     <= {`LIB_EV_W{1'b0}};
      case (st_reg)
        S_IDLE: begin
          if (up_req && !up_ack) begin
            if (!fwd_ok) begin
              up_ack   <= 1'b1;
              up_fwd   <= 1'b0;
              up_rdata <= 16'hffff;
              ev[`LIB_EV_DROP] <= 1'b1;
            end else begin
              wr_reg     <= up_wr;
              mem_reg    <= up_mem;
              wdat_reg   <= up_wdata;
              split_reg  <= up_word;
              phase_reg  <= 1'b0;
              isa_sa     <= up_addr;
              isa_sbhe_n <= ~(up_word | up_addr[0]);
              cnt_reg    <= `LIB_SET_LD;
              st_reg     <= S_SET;
            end
          end
        end
        // hold the address until iocs16_n has crossed the pin synchroniser
        S_SET: begin
          if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else begin
            st_reg <= S_ADDR;
          end
        end
        S_ADDR: begin
          if (split_reg && !phase_reg && !mem_reg && !cs16_n) begin
            wide_reg  <= 1'b1;
            split_reg <= 1'b0;
            isa_d_out <= wdat_reg;
          end else begin
            wide_reg   <= 1'b0;
            isa_sbhe_n <= ~isa_sa[0];
            isa_d_out  <= phase_reg ? {wdat_reg[15:8], wdat_reg[15:8]} : {wdat_reg[7:0], wdat_reg[7:0]};
            if (split_reg && !phase_reg) begin
              ev[`LIB_EV_SPLIT] <= 1'b1;
            end
          end
          isa_d_oe <= wr_reg;
          cnt_reg  <= CMD_LD;
          st_reg   <= S_CMD;
        end
        S_CMD: begin
          if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else if (!rdy_pin) begin
            st_reg <= S_RDY;
          end
        end
        S_RDY: begin
          if (rdy_pin) begin
            st_reg <= S_REC;
          end
        end
        S_REC: begin
          if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else if (split_reg && !phase_reg) begin
            phase_reg <= 1'b1;
            isa_sa    <= isa_sa + 20'h00001;
            st_reg    <= S_ADDR;
          end else begin
            up_ack <= 1'b1;
            up_fwd <= 1'b1;
            ev[`LIB_EV_DONE] <= 1'b1;
            st_reg <= S_IDLE;
          end
        end
        default: begin
          st_reg <= S_IDLE;
        end
      endcase
      if (done_cmd) begin
        st_reg   <= S_REC;
        cnt_reg  <= REC_LD;
        isa_d_oe <= 1'b0;
        if (!wr_reg) begin
          if (wide_reg) begin
            up_rdata <= d_pin;
          end else if (phase_reg) begin
            up_rdata[15:8] <= d_pin[7:0];
          end else begin
            up_rdata <= {8'hff, d_pin[7:0]};
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // irq routing
  wire [15:0] irq_route = {5'h1f, ctrl_reg[`LIB_C_IRQ10_ISA], ctrl_reg[`LIB_C_IRQ9_ISA], 9'h1ff};

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      host_irq <= 16'h0000;
    end else if (ce) begin
      host_irq <= irq_pin & irqen_reg & irq_route & `LIB_IRQ_SUPP;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave, one wait cycle per access
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      av_ack_reg  <= 1'b0;
      av_readdata <= 32'h00000000;
      ctrl_reg    <= `LIB_CTRL_RST;
      irqen_reg   <= 16'h0000;
      stat_reg    <= {`LIB_EV_W{1'b0}};
      mask_reg    <= {`LIB_EV_W{1'b0}};
    end else if (ce) begin
      av_ack_reg <= av_req & ~av_ack_reg;
      if (av_req && !av_ack_reg) begin
        case (av_idx)
          `LIB_REG_CTRL:  av_readdata <= {20'h00000, ctrl_reg};
          `LIB_REG_IRQEN: av_readdata <= {16'h0000, irqen_reg};
          `LIB_REG_STAT:  av_readdata <= {29'h00000000, stat_reg};
          `LIB_REG_MASK:  av_readdata <= {29'h00000000, mask_reg};
          `LIB_REG_STATE: av_readdata <= {irq_pin, 12'h000, phase_reg, st_reg};
          default:        av_readdata <= 32'h00000000;
        endcase
      end
      if (av_wr && av_idx == `LIB_REG_CTRL) begin
        ctrl_reg <= av_writedata[`LIB_CTRL_W-1:0];
      end
      if (av_wr && av_idx == `LIB_REG_IRQEN) begin
        irqen_reg <= av_writedata[15:0] & `LIB_IRQ_SUPP;
      end
      if (av_wr && av_idx == `LIB_REG_MASK) begin
        mask_reg <= av_writedata[`LIB_EV_W-1:0];
      end
      if (av_wr && av_idx == `LIB_REG_STAT) begin
        stat_reg <= (stat_reg & ~av_writedata[`LIB_EV_W-1:0]) | ev;
      end else begin
        stat_reg <= stat_reg | ev;
      end
    end
  end

endmodule

// *** design/lib_consts.vh ***
`ifndef LIB_CONSTS_VH
`define LIB_CONSTS_VH
// register word indices (byte address = index * 4)
`define LIB_REG_CTRL   3'h0
`define LIB_REG_IRQEN  3'h1
`define LIB_REG_STAT   3'h2
`define LIB_REG_MASK   3'h3
`define LIB_REG_STATE  3'h4
// control fields
`define LIB_CTRL_W       12
`define LIB_CTRL_RST     12'h263
`define LIB_C_COM1_EN    0
`define LIB_C_COM2_EN    1
`define LIB_C_COM1_SEL   5:2
`define LIB_C_COM2_SEL   9:6
`define LIB_C_IRQ9_ISA   10
`define LIB_C_IRQ10_ISA  11
// status event bits
`define LIB_EV_W       3
`define LIB_EV_DONE    0
`define LIB_EV_SPLIT   1
`define LIB_EV_DROP    2
// irq lines carried to the host
`define LIB_IRQ_SUPP   16'h9ef8
`define LIB_IRQ9       9
`define LIB_IRQ10      10
// serial port base choices
`define LIB_COM_B0     12'h200
`define LIB_COM_B1     12'h208
`define LIB_COM_B2     12'h220
`define LIB_COM_B3     12'h228
`define LIB_COM_B4     12'h238
`define LIB_COM_B5     12'h2e8
`define LIB_COM_B6     12'h338
`define LIB_COM_B7     12'h3e8
`define LIB_COM_B8     12'h3f8
`define LIB_COM_B9     12'h2f8
// address windows
`define LIB_OWN_LO     12'hc80
`define LIB_OWN_HI     12'hcbf
`define LIB_MEM_LO     20'ha0000
`define LIB_MEM_HI     20'hb7fff
`define LIB_IO_NRANGE  27
`define LIB_IO_TABLE {12'h03e,12'h03f, 12'h043,12'h04f, 12'h053,12'h05f, 12'h062,12'h062, \
  12'h066,12'h066, 12'h068,12'h070, 12'h078,12'h07f, 12'h090,12'h091, 12'h093,12'h09f, \
  12'h0a2,12'h0a3, 12'h0a6,12'h0a7, 12'h0aa,12'h0ab, 12'h0ae,12'h0af, 12'h0b6,12'h0b7, \
  12'h0ba,12'h0bb, 12'h0be,12'h2f7, 12'h2f8,12'h2ff, 12'h300,12'h3af, 12'h3bc,12'h3bf, \
  12'h3e0,12'h3f7, 12'h3f8,12'h3ff, 12'h480,12'h4cf, 12'h4d2,12'h4ff, 12'h600,12'hc7f, \
  12'hcc0,12'hcf8, 12'hcfa,12'hcfb, 12'hd00,12'hfff}
// timing
`define LIB_CLK_NS     20
`define LIB_CMD_NS     500
`define LIB_REC_NS     160
`define LIB_SET_LD     8'h03
`endif

// *** tb/lib_bridge_assertions.sv ***
`timescale 1ns/1ps
module lib_bridge_assertions (
  input logic        sys_clk,
  input logic        rst_n,
  input logic        ce,
  input logic        av_read,
  input logic        av_write,
  input logic        av_waitrequest,
  input logic        up_ack,
  input logic [19:0] isa_sa,
  input logic        isa_bale,
  input logic        isa_ior_n,
  input logic        isa_iow_n,
  input logic        isa_memr_n,
  input logic        isa_memw_n,
  input logic        isa_d_oe,
  input logic        isa_refresh_n,
  input logic [6:0]  isa_dack_n,
  input logic        isa_tc,
  input logic        isa_iochrdy,
  input logic [15:0] host_irq,
  input logic        irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_refresh_idle: assert property (isa_refresh_n) else $error("refresh active");
  a_dack_idle: assert property (isa_dack_n == 7'h7f) else $error("dma ack active");
  a_tc_low: assert property (!isa_tc) else $error("terminal count high");
  a_irq_supported: assert property ((host_irq & ~16'h9ef8) == 16'h0000) else $error("unsupported irq");
  a_mem_window: assert property (!(isa_memr_n && isa_memw_n) |-> isa_sa >= 20'ha0000 && isa_sa <= 20'hb7fff)
    else $error("memory cycle outside window");
  a_io_local: assert property (!(isa_ior_n && isa_iow_n) |-> isa_sa < 20'h01000 && (isa_sa < 20'h00c80 || isa_sa > 20'h00cbf))
    else $error("own range on bus");
  a_write_drive: assert property ($fell(isa_iow_n) |-> isa_d_oe[*4]) else $error("write data not driven");
  a_bale_strobe: assert property (isa_bale && ce |=> !isa_bale && !(isa_ior_n && isa_iow_n && isa_memr_n && isa_memw_n))
    else $error("no strobe after address");
  a_wait_one: assert property ((av_read || av_write) && av_waitrequest && ce |=> !av_waitrequest || !(av_read || av_write))
    else $error("slow register answer");
  a_ack_pulse: assert property (up_ack |=> !up_ack) else $error("ack longer than one cycle");
  a_ready_hold: assert property ($rose(isa_ior_n) || $rose(isa_iow_n) |-> $past(isa_iochrdy, 4))
    else $error("strobe ended before ready");
  c_ready_wait: cover property (!isa_iochrdy && !isa_ior_n);
  c_io_write: cover property (!isa_iow_n && isa_d_oe);
  c_mem_read: cover property (!isa_memr_n);
  c_irq_up: cover property (irq);
endmodule

// *** tb/lib_isa_module.sv ***
`timescale 1ns/1ps
module lib_isa_module (
  input  logic        sys_clk,
  input  logic        w16,
  input  logic        slow,
  input  logic [19:0] isa_sa,
  input  logic        isa_sbhe_n,
  input  logic        isa_ior_n,
  input  logic        isa_iow_n,
  input  logic [15:0] isa_d_out,
  output logic [15:0] isa_d_in,
  output logic        isa_iocs16_n,
  output logic        isa_iochrdy
);
  logic [7:0] m0 = 8'h5a, m1 = 8'ha5;
  logic [5:0] cnt = 6'h00;
  logic       wide;
  // never asks for the bus: no master or dma request line exists
  assign isa_iocs16_n = !(w16 && isa_sa[19:3] == 17'h00060);
  assign wide = !isa_iocs16_n && !isa_sbhe_n;
  assign isa_iochrdy = !(slow && !(isa_ior_n && isa_iow_n) && cnt < 6'h28);
  // released bus shows the inverse of the stored word
  assign isa_d_in = isa_ior_n ? ~{m1, m0} : wide ? {m1, m0} : {8'hff, isa_sa[0] ? m1 : m0};
  always @(posedge sys_clk) begin
    cnt <= (isa_ior_n && isa_iow_n) ? 6'h00 : cnt + (cnt != 6'h3f);
    if (!isa_iow_n && wide) begin
      {m1, m0} <= isa_d_out;
    end else if (!isa_iow_n && isa_sa[0]) begin
      m1 <= isa_d_out[7:0];
    end else if (!isa_iow_n) begin
      m0 <= isa_d_out[7:0];
    end
  end
endmodule

// *** tb/lib_bridge_bench.sv ***
`timescale 1ns/1ps
`include "lib_consts.vh"
module lib_bridge_bench;
  logic        sys_clk = 0, rst_n = 0, av_read = 0, av_write = 0, up_req = 0, up_mem = 0, up_wr = 0;
  logic        up_word = 0, up_claimed = 0, w16 = 0, slow = 0, up_ack, up_fwd, av_waitrequest, irq;
  logic [4:0]  av_address = 5'h00;
  logic [31:0] av_writedata = 32'h0, av_readdata, q;
  logic [19:0] up_addr = 20'h0, isa_sa;
  logic [15:0] up_wdata = 16'h0, isa_irq_in = 16'hffff, up_rdata, isa_d_out, isa_d_in, host_irq;
  logic        isa_sbhe_n, isa_bale, isa_ior_n, isa_iow_n, isa_memr_n, isa_memw_n, isa_d_oe;
  logic        isa_iocs16_n, isa_iochrdy, isa_refresh_n, isa_tc;
  logic [6:0]  isa_dack_n;
  int          fails = 0, comparisons = 0;
  logic [20:0] tab [14] = '{21'h00c80, 21'h00cbf, 21'h003f8, 21'h002ff, 21'h01000, 21'h00040, 21'h00300,
                            21'h00d00, 21'h00c7f, 21'h003af, 21'h19ffff, 21'h1a0000, 21'h1b7fff, 21'h1b8000};
  logic [13:0] fwd_exp = 14'h1bc0;
  lib_bridge dut_u (.sys_clk, .rst_n, .ce(1'b1), .av_address, .av_read, .av_write, .av_writedata, .av_readdata,
    .av_waitrequest, .up_req, .up_mem, .up_wr, .up_word, .up_claimed, .up_addr, .up_wdata, .up_ack, .up_fwd,
    .up_rdata, .isa_sa, .isa_sbhe_n, .isa_bale, .isa_ior_n, .isa_iow_n, .isa_memr_n, .isa_memw_n, .isa_d_out,
    .isa_d_oe, .isa_d_in, .isa_iocs16_n, .isa_iochrdy, .isa_irq_in, .isa_refresh_n, .isa_dack_n, .isa_tc,
    .host_irq, .irq);
  lib_isa_module isa_u (.sys_clk, .w16, .slow, .isa_sa, .isa_sbhe_n, .isa_ior_n, .isa_iow_n, .isa_d_out,
    .isa_d_in, .isa_iocs16_n, .isa_iochrdy);
  always #10 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    av_address <= a;
    av_writedata <= d;
    av_write <= wr;
    av_read <= !wr;
    do @(posedge sys_clk); while (av_waitrequest);
    r = av_readdata;
    av_write <= 0;
    av_read <= 0;
  endtask
  task automatic host(input logic mem, wr, word, cl, input logic [19:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    up_mem <= mem;
    up_wr <= wr;
    up_word <= word;
    up_claimed <= cl;
    up_addr <= a;
    up_wdata <= d;
    up_req <= 1;
    do @(posedge sys_clk); while (!up_ack);
    up_req <= 0;
  endtask
  task automatic probe(input logic [20:0] t, input logic f);
    host(t[20], 0, 0, 0, t[19:0], 16'h0000);
    chk(up_fwd, f);
  endtask
  task automatic complete_run;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    fails++;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1;
    repeat (6) @(posedge sys_clk);
    chk({isa_refresh_n, isa_dack_n, isa_tc}, 32'h1fe);
    chk(host_irq, 0);
    av(0, 5'h00, 0, q);
    chk(q, 32'h263);
    av(0, 5'h04, 0, q);
    chk(q, 0);
    av(0, 5'h1c, 0, q);
    chk(q, 0);
    av(0, 5'h10, 0, q);
    chk(q, 32'hffff0000);
    for (int i = 0; i < 14; i++) probe(tab[i], fwd_exp[i]);
    host(0, 0, 0, 1, 20'h00300, 16'h0000);
    chk(up_fwd, 0);
    host(0, 0, 1, 0, 20'h00c7f, 16'h0000);
    chk(up_fwd, 0);
    host(1, 0, 1, 0, 20'hb7fff, 16'h0000);
    chk(up_fwd, 0);
    w16 <= 1;
    host(0, 1, 0, 0, 20'h00300, 16'h0011);
    host(0, 1, 1, 0, 20'h00300, 16'h1234);
    host(0, 0, 1, 0, 20'h00300, 16'h0000);
    chk(up_rdata, 16'h1234);
    av(0, 5'h08, 0, q);
    chk(q[1], 0);
    av(1, 5'h08, 32'h7, q);
    w16 <= 0;
    slow <= 1;
    repeat (6) @(posedge sys_clk);
    host(0, 1, 1, 0, 20'h00300, 16'habcd);
    host(0, 0, 1, 0, 20'h00300, 16'h0000);
    chk(up_rdata, 16'habcd);
    av(0, 5'h08, 0, q);
    chk(q, 32'h3);
    av(1, 5'h00, 32'h1a2, q);
    probe(21'h003f8, 1);
    probe(21'h0033f, 0);
    probe(21'h00340, 1);
    probe(21'h002f8, 1);
    av(0, 5'h08, 0, q);
    chk(q, 32'h7);
    chk(irq, 0);
    av(1, 5'h0c, 32'h4, q);
    @(negedge sys_clk);
    chk(irq, 1);
    av(1, 5'h08, 32'h4, q);
    @(negedge sys_clk);
    chk(irq, 0);
    av(1, 5'h04, 32'hffff, q);
    av(0, 5'h04, 0, q);
    chk(q, 32'h9ef8);
    repeat (8) @(posedge sys_clk);
    chk(host_irq, 16'h98f8);
    av(1, 5'h00, 32'he63, q);
    repeat (8) @(posedge sys_clk);
    chk(host_irq, 16'h9ef8);
    complete_run;
  end
endmodule
bind lib_bridge lib_bridge_assertions chk_u (.sys_clk, .rst_n, .ce, .av_read, .av_write, .av_waitrequest, .up_ack,
  .isa_sa, .isa_bale, .isa_ior_n, .isa_iow_n, .isa_memr_n, .isa_memw_n, .isa_d_oe, .isa_refresh_n, .isa_dack_n,
  .isa_tc, .isa_iochrdy, .host_irq, .irq);
